// ===== design/alt_setting_bank.sv
// Alternate (B) regulator settings, backup charger, slave address and
// pin configuration register bank with its decoded outputs.
// Assumes the 2-wire slave and voltage control logic share clk_i.
// Functional notes
// - Buck bit 7 picks PWM(0) or PFM(1) when mode is 0 and B active.
// - Buck1/buck2 B code gives 0.3 V plus 10 mV per step.
// - Buck4 B code gives 0.53 V plus 10 mV per step.
// - Buck3 B code gives 0.80 V plus 20 mV per step.
// - LDO B code 0x02..0x38 gives 0.9..3.6 V, clamped outside.
// - LDO bit 7 forces sleep while B is selected; bit 6 reserved.
// - Charger current code decodes to off, 100..900 uA, 1..4 mA, 6 mA.
// - Termination code decodes to off, 1.1..1.8 V, 2.0..2.9 V, 3.1 V.
// - Slave answers at base field with 000 and at that plus one.
// - Address register read-only while lock fuse set; writable while it is clear.
// - High-speed fixed bit keeps slave permanently in high-speed mode.
// - Fast-mode-plus bit selects fast-mode-plus timings.
// - Interrupt output active low (0) or active high (1).
// - Reset and interrupt outputs push-pull (0) or open-drain (1).
// - Supply selects for bus pins and control inputs: core 0, I/O 1.
// - Fault hysteresis code gives 100 mV plus 50 mV per step.
// - Fault threshold code gives 2.5 V plus 50 mV per step.
// - Clock invert bits for buck3, buck4, and buck1 versus buck2.
// - Discharge bit enables active discharge of buck rails.
// - Buck mode 00 follows sleep bits, 01 PFM, 10 PWM, 11 automatic.
`timescale 1ns/1ps
module alt_setting_bank
  import alt_bank_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        arst_n_i,
  // Register port from the 2-wire slave
  input  wire logic [8:0]                  reg_addr_i,
  input  wire logic                        reg_wr_i,
  input  wire logic [7:0]                  reg_wdata_i,
  input  wire logic                        reg_rd_i,
  output logic      [7:0]                  reg_rdata_o,
  output logic                             reg_rvalid_o,
  input  wire logic                        application_lock_fuse_i,
  // Slave address match
  input  wire logic [6:0]                  bus_addr_i,
  output logic                             bus_addr_match_o,
  // Voltage control: A settings, buck modes, B select
  input  wire logic [NUM_REG-1:0][7:0]     primary_setting_i,
  input  wire logic [NUM_BUCK-1:0][1:0]    buck_operating_select_i,
  input  wire logic [NUM_REG-1:0]          alt_select_i,
  // Regulator controls
  output reg_out_type [NUM_REG-1:0]        reg_out_o,
  output op_mode_type [NUM_BUCK-1:0]       buck_op_mode_o,
  // Configuration outputs
  output pin_cfg_type                      pin_cfg_o,
  output charger_type                      charger_o,
  output fault_type                        fault_o,
  output buck_cfg_type                     buck_cfg_o,
  // Output pin drivers
  input  wire logic                        irq_assert_i,
  input  wire logic                        reset_assert_i,
  output logic                             interrupt_request_out_o,
  output logic                             interrupt_request_oe_o,
  output logic                             system_reset_out_n_o,
  output logic                             system_reset_oe_o
);

  typedef struct packed {
    logic [NUM_REG-1:0][7:0]          alt;
    logic [7:0]                       charger;
    logic [7:0]                       slave_addr;
    logic [7:0]                       pin_cfg;
    logic [7:0]                       fault_cfg;
    logic [7:0]                       clk_cfg;
    logic [7:0]                       rdata;
    logic                             rvalid;
    reg_out_type [NUM_REG-1:0]        outs;
    op_mode_type [NUM_BUCK-1:0]       modes;
    charger_type                      chg;
    fault_type                        flt;
    pin_drive_type                    pins;
  } state_type;

  state_type st_q;
  state_type st_d;

  function automatic logic [12:0] current_ua(input logic [3:0] code);
    logic [12:0] ua;
    ua = 13'd0;
    case (code)
      4'hA:    ua = 13'd1000;
      4'hB:    ua = 13'd2000;
      4'hC:    ua = 13'd3000;
      4'hD:    ua = 13'd4000;
      4'hF:    ua = 13'd6000;
      4'hE:    ua = 13'd0;
      default: ua = 13'({9'd0, code} * 13'd100);
    endcase
    return ua;
  endfunction : current_ua

  function automatic logic [11:0] term_mv(input logic [3:0] code);
    logic [11:0] mv;
    mv = 12'd0;
    case (code)
      4'h1:    mv = 12'd1100;
      4'h2:    mv = 12'd1200;
      4'h3:    mv = 12'd1400;
      4'h4:    mv = 12'd1600;
      4'h5:    mv = 12'd1800;
      4'h6:    mv = 12'd2000;
      4'h7:    mv = 12'd2200;
      4'h8:    mv = 12'd2400;
      4'h9:    mv = 12'd2500;
      4'hA:    mv = 12'd2600;
      4'hB:    mv = 12'd2700;
      4'hC:    mv = 12'd2800;
      4'hD:    mv = 12'd2900;
      4'hF:    mv = 12'd3100;
      default: mv = 12'd0;
    endcase
    return mv;
  endfunction : term_mv

  // Per-regulator selection of A or B, all combinational here
  logic [NUM_REG-1:0][7:0]   sel_set;
  reg_out_type [NUM_REG-1:0] outs_c;
  op_mode_type [NUM_BUCK-1:0] modes_c;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REG; gi++)
    begin : g_reg
      logic [5:0]  ldo_code;
      logic [11:0] base;
      logic [11:0] step;
      // Pick B only when the control logic selects it
      assign sel_set[gi] = alt_select_i[gi] ? st_q.alt[gi]
                                            : primary_setting_i[gi];
      // Out-of-range codes clamp to the end points
      assign ldo_code = (sel_set[gi][5:0] < LDO_CODE_MIN) ? LDO_CODE_MIN :
                        (sel_set[gi][5:0] > LDO_CODE_MAX) ? LDO_CODE_MAX :
                        sel_set[gi][5:0];
      if (gi < NUM_BUCK)
      begin : g_buck
        // Buck3 has double step; buck4 its own base
        assign base = (gi == 2) ? MV_BUCK3_BASE :
                      (gi == 3) ? MV_BUCK4_BASE : MV_BUCK12_BASE;
        assign step = (gi == 2) ? MV_STEP_BUCK3 : MV_STEP_FINE;
        assign outs_c[gi].level = sel_set[gi][6:0];
        assign outs_c[gi].mv    = 12'(base + step * {5'd0, sel_set[gi][6:0]});
        assign outs_c[gi].sleep = sel_set[gi][POS_SLEEP];
        // Sleep bit only matters in follow mode
        always_comb
        begin
          case (buck_operating_select_i[gi])
            MODE_FOLLOW: modes_c[gi] = sel_set[gi][POS_SLEEP] ? OP_PFM
                                                              : OP_PWM;
            MODE_PFM:    modes_c[gi] = OP_PFM;
            MODE_PWM:    modes_c[gi] = OP_PWM;
            default:     modes_c[gi] = OP_AUTO;
          endcase
        end
      end
      else
      begin : g_ldo
        assign base = MV_LDO_BASE;
        assign step = MV_STEP_LDO;
        assign outs_c[gi].level = {1'b0, ldo_code};
        // Bit 6 stored but unused
        assign outs_c[gi].mv    =
          12'(base + step * {6'd0, 6'(ldo_code - LDO_CODE_MIN)});
        assign outs_c[gi].sleep = sel_set[gi][POS_SLEEP];
      end
    end
  endgenerate

  always_comb
  begin
    logic [7:0] rd;
    logic       irq_level;
    rd        = RD_UNMAPPED;
    irq_level = 1'b0;
    st_d      = st_q;
    // Register writes; unmapped addresses are ignored
    if (reg_wr_i)
    begin
      for (int i = 0; i < NUM_REG; i++)
      begin
        if (reg_addr_i == OFS_ALT[i])
        begin
          st_d.alt[i] = reg_wdata_i;
        end
      end
      case (reg_addr_i)
        OFS_CHARGER:    st_d.charger   = reg_wdata_i;
        // Fused parts keep their address
        OFS_SLAVE_ADDR: if (!application_lock_fuse_i)
                        begin
                          st_d.slave_addr = reg_wdata_i & MASK_SLAVE_ADDR;
                        end
        OFS_PIN_CFG:    st_d.pin_cfg   = reg_wdata_i & MASK_PIN_CFG;
        OFS_FAULT_CFG:  st_d.fault_cfg = reg_wdata_i;
        OFS_CLK_CFG:    st_d.clk_cfg   = reg_wdata_i;
        default:        st_d.charger   = st_d.charger;
      endcase
    end
    // Reads return the value held before a same-cycle write
    for (int i = 0; i < NUM_REG; i++)
    begin
      if (reg_addr_i == OFS_ALT[i])
      begin
        rd = st_q.alt[i];
      end
    end
    case (reg_addr_i)
      OFS_CHARGER:    rd = st_q.charger;
      OFS_SLAVE_ADDR: rd = st_q.slave_addr;
      OFS_PIN_CFG:    rd = st_q.pin_cfg;
      OFS_FAULT_CFG:  rd = st_q.fault_cfg;
      OFS_CLK_CFG:    rd = st_q.clk_cfg;
      default:        rd = rd;
    endcase
    st_d.rvalid = reg_rd_i;
    if (reg_rd_i)
    begin
      st_d.rdata = rd;
    end
    st_d.outs  = outs_c;
    st_d.modes = modes_c;
    // Charger decode; code 1110 is treated as off
    st_d.chg.charge_current_ua  = current_ua(st_q.charger[7:4]);
    st_d.chg.charge_enable      = (current_ua(st_q.charger[7:4]) != 13'd0);
    st_d.chg.termination_mv     = term_mv(st_q.charger[3:0]);
    st_d.chg.termination_enable = (term_mv(st_q.charger[3:0]) != 12'd0);
    // Comparator settings
    st_d.flt.hysteresis_mv = 9'(MV_HYST_BASE + MV_HYST_STEP *
      {6'd0, st_q.fault_cfg[POS_HYST_LO +: 3]});
    st_d.flt.threshold_mv  = 12'(MV_FAULT_BASE + MV_FAULT_STEP *
      {8'd0, st_q.fault_cfg[3:0]});
    // Polarity applies before drive type
    irq_level = st_q.pin_cfg[POS_IRQ_POL] ? irq_assert_i : !irq_assert_i;
    if (st_q.pin_cfg[POS_DRIVE_TYPE])
    begin
      // Open-drain only ever pulls low
      st_d.pins.irq_out = 1'b0;
      st_d.pins.irq_oe  = !irq_level;
      st_d.pins.rst_out = 1'b0;
      st_d.pins.rst_oe  = reset_assert_i;
    end
    else
    begin
      st_d.pins.irq_out = irq_level;
      st_d.pins.irq_oe  = 1'b1;
      st_d.pins.rst_out = !reset_assert_i;
      st_d.pins.rst_oe  = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q            <= '0;
      st_q.alt        <= {NUM_REG{RST_ALT}};
      st_q.charger    <= RST_CHARGER;
      st_q.slave_addr <= RST_SLAVE_ADDR;
      st_q.pin_cfg    <= RST_PIN_CFG;
      st_q.fault_cfg  <= RST_FAULT_CFG;
      st_q.clk_cfg    <= RST_CLK_CFG;
      st_q.pins       <= RST_PINS;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Either LSB is accepted, upper address bits must match
  assign bus_addr_match_o =
    (bus_addr_i[6:1] == {st_q.slave_addr[7:POS_ADDR_LO], 2'b00});

  assign reg_rdata_o  = st_q.rdata;
  assign reg_rvalid_o = st_q.rvalid;
  assign reg_out_o    = st_q.outs;
  assign buck_op_mode_o = st_q.modes;
  assign charger_o    = st_q.chg;
  assign fault_o      = st_q.flt;

  // Static configuration taken straight from the registers
  assign pin_cfg_o.high_speed_fixed = st_q.pin_cfg[POS_HS_FIXED];
  assign pin_cfg_o.fast_plus_select = st_q.pin_cfg[POS_FAST_PLUS];
  assign pin_cfg_o.bus_pin_supply_select =
    st_q.pin_cfg[POS_BUS_SUPPLY];
  assign pin_cfg_o.control_input_supply_select =
    st_q.pin_cfg[POS_IN_SUPPLY];
  assign pin_cfg_o.irq_active_high   = st_q.pin_cfg[POS_IRQ_POL];
  assign pin_cfg_o.output_drive_type = st_q.pin_cfg[POS_DRIVE_TYPE];

  assign buck_cfg_o.buck1_clock_invert = st_q.clk_cfg[POS_B1_INV];
  assign buck_cfg_o.buck3_clock_invert = st_q.clk_cfg[POS_B3_INV];
  assign buck_cfg_o.buck4_clock_invert = st_q.clk_cfg[POS_B4_INV];
  assign buck_cfg_o.rail_active_discharge =
    st_q.clk_cfg[POS_DISCHARGE];

  assign interrupt_request_out_o = st_q.pins.irq_out;
  assign interrupt_request_oe_o  = st_q.pins.irq_oe;
  assign system_reset_out_n_o    = st_q.pins.rst_out;
  assign system_reset_oe_o       = st_q.pins.rst_oe;

endmodule : alt_setting_bank

// ===== design/alt_bank_pkg.sv
// Constants, field layouts and carrier types for the alternate
// regulator setting and pin configuration byte register bank.
// Assumes a byte-wide register port driven by the 2-wire slave logic.
package alt_bank_pkg;

  // Register offsets (9-bit register address space)
  localparam logic [8:0] OFS_BUCK2_ALT    = 9'h0B4;
  localparam logic [8:0] OFS_BUCK1_ALT    = 9'h0B5;
  localparam logic [8:0] OFS_BUCK4_ALT    = 9'h0B6;
  localparam logic [8:0] OFS_BUCK3_ALT    = 9'h0B8;
  localparam logic [8:0] OFS_LDO1_ALT     = 9'h0BA;
  localparam logic [8:0] OFS_LDO2_ALT     = 9'h0BB;
  localparam logic [8:0] OFS_LDO3_ALT     = 9'h0BC;
  localparam logic [8:0] OFS_LDO4_ALT     = 9'h0BD;
  localparam logic [8:0] OFS_CHARGER      = 9'h0C5;
  localparam logic [8:0] OFS_SLAVE_ADDR   = 9'h105;
  localparam logic [8:0] OFS_PIN_CFG      = 9'h106;
  localparam logic [8:0] OFS_FAULT_CFG    = 9'h107;
  localparam logic [8:0] OFS_CLK_CFG      = 9'h108;

  // Regulator index: 0..3 buck1..buck4, 4..7 ldo1..ldo4
  localparam int unsigned NUM_REG  = 8;
  localparam int unsigned NUM_BUCK = 4;
  localparam logic [NUM_REG-1:0][8:0] OFS_ALT = {
    OFS_LDO4_ALT, OFS_LDO3_ALT, OFS_LDO2_ALT, OFS_LDO1_ALT,
    OFS_BUCK4_ALT, OFS_BUCK3_ALT, OFS_BUCK2_ALT, OFS_BUCK1_ALT};

  // Field positions
  localparam int unsigned POS_SLEEP      = 7;
  localparam int unsigned POS_ADDR_LO    = 4;
  localparam int unsigned POS_HS_FIXED   = 6;
  localparam int unsigned POS_FAST_PLUS  = 5;
  localparam int unsigned POS_BUS_SUPPLY = 4;
  localparam int unsigned POS_IRQ_POL    = 3;
  localparam int unsigned POS_DRIVE_TYPE = 2;
  localparam int unsigned POS_IN_SUPPLY  = 0;
  localparam int unsigned POS_HYST_LO    = 4;
  localparam int unsigned POS_B3_INV     = 6;
  localparam int unsigned POS_B4_INV     = 4;
  localparam int unsigned POS_B1_INV     = 3;
  localparam int unsigned POS_DISCHARGE  = 2;

  // Masks of bits that read back; the rest read zero
  localparam logic [7:0] MASK_SLAVE_ADDR = 8'hF0;
  localparam logic [7:0] MASK_PIN_CFG    = 8'h7F;

  // Values after reset
  localparam logic [7:0] RST_ALT         = 8'h00;
  localparam logic [7:0] RST_CHARGER     = 8'h00;
  localparam logic [7:0] RST_SLAVE_ADDR  = 8'h00;
  localparam logic [7:0] RST_PIN_CFG     = 8'h00;
  localparam logic [7:0] RST_FAULT_CFG   = 8'h00;
  localparam logic [7:0] RST_CLK_CFG     = 8'h00;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;
  // Pins in reset: both enables on, both levels low
  localparam logic [3:0] RST_PINS        = 4'h5;

  // Voltage code scaling, millivolts
  localparam logic [11:0] MV_BUCK12_BASE = 12'd300;
  localparam logic [11:0] MV_BUCK4_BASE  = 12'd530;
  localparam logic [11:0] MV_BUCK3_BASE  = 12'd800;
  localparam logic [11:0] MV_LDO_BASE    = 12'd900;
  localparam logic [11:0] MV_STEP_FINE   = 12'd10;
  localparam logic [11:0] MV_STEP_BUCK3  = 12'd20;
  localparam logic [11:0] MV_STEP_LDO    = 12'd50;
  localparam logic [5:0]  LDO_CODE_MIN   = 6'h02;
  localparam logic [5:0]  LDO_CODE_MAX   = 6'h38;
  localparam logic [8:0]  MV_HYST_BASE   = 9'd100;
  localparam logic [8:0]  MV_HYST_STEP   = 9'd50;
  localparam logic [11:0] MV_FAULT_BASE  = 12'd2500;
  localparam logic [11:0] MV_FAULT_STEP  = 12'd50;

  typedef enum logic [1:0] {
    OP_PWM,
    OP_PFM,
    OP_AUTO
  } op_mode_type;

  // Mode field values of a buck
  localparam logic [1:0] MODE_FOLLOW = 2'h0;
  localparam logic [1:0] MODE_PFM    = 2'h1;
  localparam logic [1:0] MODE_PWM    = 2'h2;

  typedef struct packed {
    logic [6:0]  level;
    logic [11:0] mv;
    logic        sleep;
  } reg_out_type;

  typedef struct packed {
    logic        high_speed_fixed;
    logic        fast_plus_select;
    logic        bus_pin_supply_select;
    logic        control_input_supply_select;
    logic        irq_active_high;
    logic        output_drive_type;
  } pin_cfg_type;

  typedef struct packed {
    logic [12:0] charge_current_ua;
    logic        charge_enable;
    logic [11:0] termination_mv;
    logic        termination_enable;
  } charger_type;

  typedef struct packed {
    logic [8:0]  hysteresis_mv;
    logic [11:0] threshold_mv;
  } fault_type;

  typedef struct packed {
    logic buck1_clock_invert;
    logic buck3_clock_invert;
    logic buck4_clock_invert;
    logic rail_active_discharge;
  } buck_cfg_type;

  typedef struct packed {
    logic irq_out;
    logic irq_oe;
    logic rst_out;
    logic rst_oe;
  } pin_drive_type;

endpackage : alt_bank_pkg

// ===== dv/alt_bank_asserts.sv
// Port relation checker for the alternate setting bank.
// Assumes it is bound onto alt_setting_bank; one clock domain.
`timescale 1ns/1ps
module alt_bank_asserts
  import alt_bank_pkg::*;
(
  // Clock and reset
  input wire logic                     clk_i,
  input wire logic                     arst_n_i,
  // Observed ports
  input wire logic                     reg_rd_i,
  input wire logic                     reg_rvalid_o,
  input wire logic [6:0]               bus_addr_i,
  input wire logic                     bus_addr_match_o,
  input wire logic [NUM_BUCK-1:0][1:0] buck_operating_select_i,
  input wire reg_out_type [NUM_REG-1:0] reg_out_o,
  input wire op_mode_type [NUM_BUCK-1:0] buck_op_mode_o,
  input wire pin_cfg_type              pin_cfg_o,
  input wire logic                     irq_assert_i,
  input wire logic                     reset_assert_i,
  input wire logic                     interrupt_request_out_o,
  input wire logic                     interrupt_request_oe_o,
  input wire logic                     system_reset_out_n_o,
  input wire logic                     system_reset_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  function automatic logic [11:0] exp_mv(input int i, input logic [6:0] c);
    case (i)
      0, 1: return 12'h12C + 12'(c) * 12'h00A;
      2: return 12'h320 + 12'(c) * 12'h014;
      3: return 12'h212 + 12'(c) * 12'h00A;
      default: return 12'h384 + (12'(c) - 12'h002) * 12'h032;
    endcase
  endfunction : exp_mv

  function automatic op_mode_type mode_of(input logic [1:0] m, input logic s);
    case (m)
      2'h0: return s ? OP_PFM : OP_PWM;
      2'h1: return OP_PFM;
      2'h2: return OP_PWM;
      default: return OP_AUTO;
    endcase
  endfunction : mode_of

  sequence s_read; reg_rd_i; endsequence
  sequence s_answer; reg_rvalid_o; endsequence
  property p_rvalid_after_read; s_read |=> s_answer; endproperty
  a_rvalid_after_read: assert property (p_rvalid_after_read)
    else $error("read not answered one cycle later");
  property p_rvalid_single; !reg_rd_i |=> !reg_rvalid_o; endproperty
  a_rvalid_single: assert property (p_rvalid_single)
    else $error("read valid without a read");
  property p_addr_pair; bus_addr_match_o |-> bus_addr_i[2:1] == 2'h0;
  endproperty
  a_addr_pair: assert property (p_addr_pair)
    else $error("match outside the address pair");
  // Pins lag their causes by one cycle, so causes are taken from $past
  property p_irq_push;
    $past(arst_n_i) && !$past(pin_cfg_o.output_drive_type) |->
      interrupt_request_oe_o && interrupt_request_out_o ==
      ($past(pin_cfg_o.irq_active_high) ~^ $past(irq_assert_i));
  endproperty
  a_irq_push: assert property (p_irq_push)
    else $error("push-pull interrupt level wrong");
  property p_rst_push;
    $past(arst_n_i) && !$past(pin_cfg_o.output_drive_type) |->
      system_reset_oe_o && system_reset_out_n_o == !$past(reset_assert_i);
  endproperty
  a_rst_push: assert property (p_rst_push)
    else $error("push-pull reset level wrong");
  property p_open_drain;
    $past(arst_n_i) && $past(pin_cfg_o.output_drive_type) |->
      !interrupt_request_out_o && !system_reset_out_n_o &&
      system_reset_oe_o == $past(reset_assert_i) && interrupt_request_oe_o ==
      ($past(pin_cfg_o.irq_active_high) ^ $past(irq_assert_i));
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin drive wrong");

  for (genvar i = 0; i < NUM_REG; i++)
  begin : g_reg
    property p_mv_scale;
      $past(arst_n_i) |-> reg_out_o[i].mv == exp_mv(i, reg_out_o[i].level);
    endproperty
    a_mv_scale: assert property (p_mv_scale)
      else $error("voltage scale mismatch");
    if (i >= NUM_BUCK)
    begin : g_ldo
      property p_ldo_clamp;
        $past(arst_n_i) |-> reg_out_o[i].level inside {[7'h02:7'h38]};
      endproperty
      a_ldo_clamp: assert property (p_ldo_clamp)
        else $error("ldo code not clamped");
    end
    else
    begin : g_buck
      property p_mode_map;
        $past(arst_n_i) |-> buck_op_mode_o[i] ==
          mode_of($past(buck_operating_select_i[i]), reg_out_o[i].sleep);
      endproperty
      a_mode_map: assert property (p_mode_map)
        else $error("buck operating mode wrong");
    end
  end
endmodule : alt_bank_asserts

// ===== dv/host_port_model.sv
// Host side of the byte register port, as the 2-wire slave presents it.
// Assumes the bench calls its tasks; drives 1 ns after the rising edge.
`timescale 1ns/1ps
module host_port_model
(
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic [8:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial
  begin
    reg_addr_o = 9'h000;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end
  // Address and data flip after use so a stale address never passes as valid
  task automatic write_byte(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : write_byte
  task automatic read_byte(input logic [8:0] a, output logic [7:0] d,
                           output logic ok);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    ok = reg_rvalid_i;
    d = reg_rdata_i;
  endtask : read_byte
endmodule : host_port_model

// ===== dv/alt_setting_bank_tb.sv
// Self-checking bench for the alternate setting bank.
// Assumes the checker file and host model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] %s exp %0h got %0h", n, (e), (g)); end end
module alt_setting_bank_tb
  import alt_bank_pkg::*;
;
  logic clk_i, arst_n_i, fuse, irq_a, rst_a, ok, match, rvalid;
  logic irq_o, irq_oe, rst_o, rst_oe;
  logic [6:0] bus_addr;
  logic [7:0] alt_sel, rdata, d;
  logic [NUM_REG-1:0][7:0] prim;
  logic [NUM_BUCK-1:0][1:0] mode_sel;
  logic [8:0] addr;
  logic wstb, rd;
  logic [7:0] wdata;
  reg_out_type [NUM_REG-1:0] rout;
  op_mode_type [NUM_BUCK-1:0] opm;
  pin_cfg_type pcfg;
  charger_type chg;
  fault_type flt;
  buck_cfg_type bcfg;
  int bad_count, check_count;
  // Last entry is unmapped
  logic [8:0] ofs [14] = '{OFS_BUCK2_ALT, OFS_BUCK1_ALT, OFS_BUCK4_ALT,
    OFS_BUCK3_ALT, OFS_LDO1_ALT, OFS_LDO2_ALT, OFS_LDO3_ALT, OFS_LDO4_ALT,
    OFS_CHARGER, OFS_SLAVE_ADDR, OFS_PIN_CFG, OFS_FAULT_CFG, OFS_CLK_CFG,
    9'h0B7};
  // B bytes per regulator index and expected level, mv, sleep
  logic [7:0] vb [8] = '{8'hFF, 8'h00, 8'h7F, 8'h7F, 8'h3F, 8'h81, 8'h4A,
    8'h38};
  logic [19:0] vexp [8] = '{{7'h7F, 12'h622, 1'b1}, {7'h00, 12'h12C, 1'b0},
    {7'h7F, 12'hD0C, 1'b0}, {7'h7F, 12'h708, 1'b0}, {7'h38, 12'hE10, 1'b0},
    {7'h02, 12'h384, 1'b1}, {7'h0A, 12'h514, 1'b0}, {7'h38, 12'hE10, 1'b0}};
  logic [12:0] ua [16] = '{13'h000, 13'h064, 13'h0C8, 13'h12C, 13'h190,
    13'h1F4, 13'h258, 13'h2BC, 13'h320, 13'h384, 13'h3E8, 13'h7D0, 13'hBB8,
    13'hFA0, 13'h000, 13'h1770};
  logic [11:0] tmv [16] = '{12'h000, 12'h44C, 12'h4B0, 12'h578, 12'h640,
    12'h708, 12'h7D0, 12'h898, 12'h960, 12'h9C4, 12'hA28, 12'hA8C, 12'hAF0,
    12'hB54, 12'h000, 12'hC1C};

  host_port_model host_port_model_i (.clk_i(clk_i), .reg_addr_o(addr),
    .reg_wr_o(wstb), .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid));
  alt_setting_bank alt_setting_bank_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(addr), .reg_wr_i(wstb), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .application_lock_fuse_i(fuse), .bus_addr_i(bus_addr),
    .bus_addr_match_o(match), .primary_setting_i(prim),
    .buck_operating_select_i(mode_sel), .alt_select_i(alt_sel),
    .reg_out_o(rout), .buck_op_mode_o(opm), .pin_cfg_o(pcfg),
    .charger_o(chg), .fault_o(flt), .buck_cfg_o(bcfg),
    .irq_assert_i(irq_a), .reset_assert_i(rst_a),
    .interrupt_request_out_o(irq_o), .interrupt_request_oe_o(irq_oe),
    .system_reset_out_n_o(rst_o), .system_reset_oe_o(rst_oe));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic rd_chk(input string n, input logic [8:0] a,
                        input logic [7:0] e);
    host_port_model_i.read_byte(a, d, ok);
    `CHK("rvalid", 1'b1, ok)
    `CHK(n, e, d)
  endtask : rd_chk
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    host_port_model_i.write_byte(a, v);
    repeat (2) @(posedge clk_i);
    #1;
  endtask : wr
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    {arst_n_i, fuse, irq_a, rst_a, bus_addr, prim, mode_sel} = '0;
    alt_sel = 8'hFF;
    bad_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    for (int i = 0; i < 14; i++)
      rd_chk("reset value", ofs[i], 8'h00);
    for (int i = 0; i < 14; i++)
    begin
      wr(ofs[i], 8'hFF);
      rd_chk("readback", ofs[i], i == 9 ? 8'hF0 : i == 10 ? 8'h7F :
             i == 13 ? 8'h00 : 8'hFF);
    end
    fuse = 1'b1;
    wr(OFS_SLAVE_ADDR, 8'h50);
    rd_chk("locked address", OFS_SLAVE_ADDR, 8'hF0);
    fuse = 1'b0;
    wr(OFS_SLAVE_ADDR, 8'h50);
    rd_chk("unlocked address", OFS_SLAVE_ADDR, 8'h50);
    // Host may use either address of the pair
    for (int a = 8'h27; a < 8'h2B; a++)
    begin
      bus_addr = 7'(a);
      @(posedge clk_i);
      #1 `CHK("address match", a == 8'h28 || a == 8'h29, match)
    end
    irq_a = 1'b1;
    wr(OFS_PIN_CFG, 8'h59);
    `CHK("pin config", 6'h2E, pcfg)
    `CHK("push-pull pins", 4'hF, {irq_o, irq_oe, rst_o, rst_oe})
    rst_a = 1'b1;
    wr(OFS_PIN_CFG, 8'h26);
    `CHK("pin config", 6'h11, pcfg)
    `CHK("open-drain pins", 4'h5, {irq_o, irq_oe, rst_o, rst_oe})
    {irq_a, rst_a} = 2'h0;
    wr(OFS_CLK_CFG, 8'h48);
    `CHK("buck config", 4'hC, bcfg)
    wr(OFS_CLK_CFG, 8'h14);
    `CHK("buck config", 4'h3, bcfg)
    wr(OFS_FAULT_CFG, 8'h7F);
    `CHK("fault config", {9'h1C2, 12'hCB2}, flt)
    wr(OFS_FAULT_CFG, 8'h35);
    `CHK("fault config", {9'h0FA, 12'hABE}, flt)
    for (int c = 0; c < 16; c++)
    begin
      wr(OFS_CHARGER, {4'(c), 4'(c)});
      `CHK("charger", {ua[c], |ua[c], tmv[c], |tmv[c]}, chg)
    end
    for (int i = 0; i < 8; i++)
      host_port_model_i.write_byte(OFS_ALT[i], vb[i]);
    wr(OFS_ALT[0], vb[0]);
    for (int i = 0; i < 8; i++)
      `CHK("alt output", vexp[i], rout[i])
    `CHK("follow modes", {OP_PWM, OP_PWM, OP_PWM, OP_PFM}, opm)
    mode_sel = {2'h3, 2'h2, 2'h1, 2'h0};
    repeat (2) @(posedge clk_i);
    #1 `CHK("forced modes", {OP_AUTO, OP_PWM, OP_PFM, OP_PFM}, opm)
    alt_sel = 8'hEE;
    prim[0] = 8'h85;
    prim[4] = 8'h00;
    repeat (2) @(posedge clk_i);
    #1 `CHK("primary buck", {7'h05, 12'h15E, 1'b1}, rout[0])
    `CHK("primary ldo", {7'h02, 12'h384, 1'b0}, rout[4])
    give_verdict();
  end
endmodule : alt_setting_bank_tb

bind alt_setting_bank alt_bank_asserts alt_bank_asserts_i (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
  .bus_addr_i(bus_addr_i), .bus_addr_match_o(bus_addr_match_o),
  .buck_operating_select_i(buck_operating_select_i), .reg_out_o(reg_out_o),
  .buck_op_mode_o(buck_op_mode_o), .pin_cfg_o(pin_cfg_o),
  .irq_assert_i(irq_assert_i), .reset_assert_i(reset_assert_i),
  .interrupt_request_out_o(interrupt_request_out_o),
  .interrupt_request_oe_o(interrupt_request_oe_o),
  .system_reset_out_n_o(system_reset_out_n_o),
  .system_reset_oe_o(system_reset_oe_o));
